// ---- ipv_pkg.sv ----
`default_nettype none

package ipv_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_PRIO_LOW_FIRST   = 8'hef;
  localparam logic [7:0] OFS_PRIO_HIGH_FIRST  = 8'hf7;
  localparam logic [7:0] OFS_PRIO_LOW_SECOND  = 8'hfe;
  localparam logic [7:0] OFS_PRIO_HIGH_SECOND = 8'hff;
  localparam logic [7:0] OFS_EXT_CTRL         = 8'h88;

  // ==========================================================
  // Masks and reset values
  localparam logic [7:0] MASK_FIRST    = 8'hbf;
  localparam logic [7:0] MASK_SECOND   = 8'h07;
  localparam logic [7:0] RST_PRIO      = 8'h00;
  localparam logic [1:0] RST_TYPE      = 2'h0;

  // ==========================================================
  // Ext control register field positions
  localparam int BIT_ZERO_TYPE = 0;
  localparam int BIT_ZERO_FLAG = 1;
  localparam int BIT_ONE_TYPE  = 2;
  localparam int BIT_ONE_FLAG  = 3;

  // ==========================================================
  // Sources in natural order, index 0 first
  localparam int NSRC = 12;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_WDT  = 1;
  localparam int SRC_TWI  = 2;
  localparam int SRC_EXT1 = 3;
  localparam int SRC_PIN  = 4;
  localparam int SRC_T2A  = 5;
  localparam int SRC_T2B  = 6;
  localparam int SRC_T2C  = 7;
  localparam int SRC_T2D  = 8;
  localparam int SRC_SER1 = 9;
  localparam int SRC_T3   = 10;
  localparam int SRC_WKT  = 11;

  // Vector addresses by source
  localparam logic [15:0] VEC_TABLE [NSRC] = '{
    16'h0003, 16'h0053, 16'h0033, 16'h0013, 16'h003b, 16'h002b,
    16'h0063, 16'h006b, 16'h0073, 16'h007b, 16'h0083, 16'h008b};

  // ==========================================================
  // Timing
  localparam int CALL_CYCLES = 4;
  localparam int MAX_LATENCY = 16;

  // ==========================================================
  // Call sequencer states
  typedef enum logic [1:0]
  {
    IPV_IDLE = 2'b00,
    IPV_CALL = 2'b01
  } ipv_state_t;

endpackage : ipv_pkg

`default_nettype wire

// ---- ipv_ctrl.sv ----
// What this block does
// (RULE1) Poll and resolve all flags every cycle
// (RULE2) Block call if equal/higher level serviced
// (RULE3) Call only on instruction last cycle
// (RULE4) Block on priority/enable write or return; code blocks on instr_writes_ie and interrupt return, not on reg_wr
// (RULE5) Blocked requests are not remembered
// (RULE6) Push PC, then load vector address
// (RULE7) Interrupt return pops PC, ends service
// (RULE8) Plain return pops, keeps in-service set
// (RULE9) Vector call lasts four clock cycles
// (RULE10) Single-source latency at most sixteen cycles
// (RULE11) Type bit picks edge or level
// (RULE12) Edge mode: high then low sets flag
// (RULE13) Edge flag cleared on vector entry
// (RULE14) Level flag follows inverted pin
// (RULE15) Held low level re-requests after return
// (RULE16) Requester holds pin one cycle minimum
// (RULE17) Either external pin wakes power-down
// (RULE18) Level is high bit and low bit
// (RULE19) First low register bit layout
// (RULE20) First high register same layout
// (RULE21) Second low register bit layout
// (RULE22) Second high register bit layout
// (RULE23) Highest level wins, then natural order
// (RULE24) Level 3 highest, one marker per level
// (RULE25) Reserved bits read zero, ignore writes
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module ipv_ctrl
  import ipv_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // External interrupt pins
  input  wire logic        ext_irq_pin_zero,
  input  wire logic        ext_irq_pin_one,
  // Peripheral flags, bits 0 and 3 unused
  input  wire logic [11:0] src_flag,
  // Core handshake
  input  wire logic        instr_last_cycle,
  input  wire logic        instr_writes_ie,
  input  wire logic        instr_is_return_from_interrupt,
  input  wire logic        instr_is_ret,
  input  wire logic [15:0] core_pc,
  // Vector call outputs
  output logic             call_start,
  output logic             call_busy,
  output logic             stack_push,
  output logic      [15:0] push_pc,
  output logic             pc_load,
  output logic      [15:0] pc_vector,
  output logic             stack_pop,
  output logic      [3:0]  ack_src,
  output logic             ack_valid,
  output logic      [3:0]  in_service,
  output logic             wake_up
);

  // ==========================================================
  // State
  typedef struct packed
  {
    logic [7:0]  low_first;
    logic [7:0]  high_first;
    logic [7:0]  low_second;
    logic [7:0]  high_second;
    logic [1:0]  type_sel;
    logic [1:0]  edge_flag;
    logic [1:0]  pin_s1;
    logic [1:0]  pin_s2;
    logic [1:0]  pin_s3;
    logic [3:0]  isr;
    ipv_state_t  state;
    logic [1:0]  cnt;
    logic [3:0]  win;
    logic [15:0] vec;
    logic [15:0] pc_hold;
    logic [7:0]  rdata;
    logic        push;
    logic        load;
    logic        pop;
    logic        start;
    logic        ack;
  } ipv_regs_t;

  ipv_regs_t cur_ff;
  ipv_regs_t nxt_ff;
  default disable iff (!nrst);

  // ==========================================================
  // Functions
  function automatic logic [1:0] src_level(input ipv_regs_t r,
                                           input int s);
    logic [1:0] lv;
    lv = 2'h0;
    case (s)
      SRC_T2D:  lv = {r.high_first[7], r.low_first[7]};
      SRC_T2C:  lv = {r.high_first[5], r.low_first[5]};
      SRC_WDT:  lv = {r.high_first[4], r.low_first[4]};
      SRC_T2B:  lv = {r.high_first[3], r.low_first[3]};
      SRC_T2A:  lv = {r.high_first[2], r.low_first[2]};
      SRC_PIN:  lv = {r.high_first[1], r.low_first[1]};
      SRC_TWI:  lv = {r.high_first[0], r.low_first[0]};
      SRC_WKT:  lv = {r.high_second[2], r.low_second[2]};
      SRC_T3:   lv = {r.high_second[1], r.low_second[1]};
      SRC_SER1: lv = {r.high_second[0], r.low_second[0]};
      default:  lv = 2'h0;
    endcase
    return lv; // see RULE18 see RULE19 see RULE20 see RULE21 see RULE22
  endfunction : src_level

  function automatic logic level_blocked(input logic [3:0] isr,
                                         input logic [1:0] lv);
    logic b;
    b = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (isr[i] && (i >= int'(lv)))
      begin
        b = 1'b1;
      end
    end
    return b; // see RULE2
  endfunction : level_blocked

  // ==========================================================
  // Combinational signals
  logic [1:0]  ext_flag;
  logic [11:0] req;
  logic        found;
  logic [3:0]  best_src;
  logic [1:0]  best_lv;
  logic [1:0]  lv_tmp;
  logic        take;
  logic [1:0]  fall;

  always_comb
  begin
    nxt_ff   = cur_ff;
    found    = 1'b0;
    best_src = 4'h0;
    best_lv  = 2'h0;
    lv_tmp   = 2'h0;
    fall     = cur_ff.pin_s3 & ~cur_ff.pin_s2; // see RULE12

    // Level mode flag is the inverted synchronised pin
    for (int e = 0; e < 2; e++)
    begin
      if (cur_ff.type_sel[e])
      begin
        ext_flag[e] = cur_ff.edge_flag[e]; // see RULE11
      end
      else
      begin
        ext_flag[e] = ~cur_ff.pin_s2[e]; // see RULE14 see RULE15
      end
    end

    req           = src_flag;
    req[SRC_EXT0] = ext_flag[0];
    req[SRC_EXT1] = ext_flag[1];

    // Resolve afresh every cycle, no memory of losers
    for (int s = 0; s < NSRC; s++)
    begin
      lv_tmp = src_level(cur_ff, s);
      if (req[s] && (!found || (lv_tmp > best_lv)))
      begin
        found    = 1'b1; // see RULE1 see RULE5 see RULE23 see RULE24
        best_src = 4'(s);
        best_lv  = lv_tmp;
      end
    end

    take = found && (cur_ff.state == IPV_IDLE) && instr_last_cycle
           && !instr_writes_ie && !instr_is_return_from_interrupt
           && !level_blocked(cur_ff.isr, best_lv); // see RULE3 see RULE4

    // Pin synchronisers
    nxt_ff.pin_s1 = {ext_irq_pin_one, ext_irq_pin_zero};
    nxt_ff.pin_s2 = cur_ff.pin_s1;
    nxt_ff.pin_s3 = cur_ff.pin_s2;

    nxt_ff.push  = 1'b0;
    nxt_ff.load  = 1'b0;
    nxt_ff.pop   = 1'b0;
    nxt_ff.start = 1'b0;
    nxt_ff.ack   = 1'b0;

    // Register writes
    if (reg_wr)
    begin
      if (reg_addr == OFS_PRIO_LOW_FIRST)
      begin
        nxt_ff.low_first = reg_wdata & MASK_FIRST; // see RULE25
      end
      else if (reg_addr == OFS_PRIO_HIGH_FIRST)
      begin
        nxt_ff.high_first = reg_wdata & MASK_FIRST;
      end
      else if (reg_addr == OFS_PRIO_LOW_SECOND)
      begin
        nxt_ff.low_second = reg_wdata & MASK_SECOND;
      end
      else if (reg_addr == OFS_PRIO_HIGH_SECOND)
      begin
        nxt_ff.high_second = reg_wdata & MASK_SECOND;
      end
      else if (reg_addr == OFS_EXT_CTRL)
      begin
        nxt_ff.type_sel  = {reg_wdata[BIT_ONE_TYPE],
                            reg_wdata[BIT_ZERO_TYPE]};
        nxt_ff.edge_flag = {reg_wdata[BIT_ONE_FLAG],
                            reg_wdata[BIT_ZERO_FLAG]};
      end
    end

    // Vector call sequencer
    case (cur_ff.state)
      IPV_IDLE:
      begin
        if (take)
        begin
          nxt_ff.state   = IPV_CALL;
          nxt_ff.cnt     = 2'(CALL_CYCLES - 1);
          nxt_ff.win     = best_src;
          nxt_ff.vec     = VEC_TABLE[best_src];
          nxt_ff.pc_hold = core_pc;
          nxt_ff.push    = 1'b1; // see RULE6
          nxt_ff.start   = 1'b1;
          nxt_ff.ack     = 1'b1;
          nxt_ff.isr[best_lv] = 1'b1;
          if ((best_src == 4'(SRC_EXT0)) && cur_ff.type_sel[0])
          begin
            nxt_ff.edge_flag[0] = 1'b0; // see RULE13
          end
          if ((best_src == 4'(SRC_EXT1)) && cur_ff.type_sel[1])
          begin
            nxt_ff.edge_flag[1] = 1'b0;
          end
        end
        else if (instr_is_return_from_interrupt && instr_last_cycle)
        begin
          nxt_ff.pop = 1'b1; // see RULE7
          for (int i = 3; i >= 0; i--)
          begin
            if (cur_ff.isr[i] && (nxt_ff.isr == cur_ff.isr))
            begin
              nxt_ff.isr[i] = 1'b0;
            end
          end
        end
        else if (instr_is_ret && instr_last_cycle)
        begin
          nxt_ff.pop = 1'b1; // see RULE8
        end
      end
      IPV_CALL:
      begin
        if (cur_ff.cnt == 2'h2)
        begin
          nxt_ff.load = 1'b1; // see RULE9 see RULE10
        end
        if (cur_ff.cnt == 2'h0)
        begin
          nxt_ff.state = IPV_IDLE;
        end
        nxt_ff.cnt = cur_ff.cnt - 2'h1;
      end
      default:
      begin
        nxt_ff.state = IPV_IDLE;
      end
    endcase

    // Edge detection, set wins over software or entry clear
    for (int e = 0; e < 2; e++)
    begin
      if (cur_ff.type_sel[e] && fall[e])
      begin
        nxt_ff.edge_flag[e] = 1'b1; // see RULE12
      end
    end

    // Register reads
    nxt_ff.rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == OFS_PRIO_LOW_FIRST)
      begin
        nxt_ff.rdata = cur_ff.low_first;
      end
      else if (reg_addr == OFS_PRIO_HIGH_FIRST)
      begin
        nxt_ff.rdata = cur_ff.high_first;
      end
      else if (reg_addr == OFS_PRIO_LOW_SECOND)
      begin
        nxt_ff.rdata = cur_ff.low_second;
      end
      else if (reg_addr == OFS_PRIO_HIGH_SECOND)
      begin
        nxt_ff.rdata = cur_ff.high_second;
      end
      else if (reg_addr == OFS_EXT_CTRL)
      begin
        nxt_ff.rdata = {4'h0, ext_flag[1], cur_ff.type_sel[1],
                        ext_flag[0], cur_ff.type_sel[0]};
      end
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff <= '{low_first: RST_PRIO, high_first: RST_PRIO,
                  low_second: RST_PRIO, high_second: RST_PRIO,
                  type_sel: RST_TYPE, edge_flag: 2'h0,
                  pin_s1: 2'h3, pin_s2: 2'h3, pin_s3: 2'h3,
                  isr: 4'h0, state: IPV_IDLE, cnt: 2'h0,
                  win: 4'h0, vec: 16'h0000, pc_hold: 16'h0000,
                  rdata: 8'h00, push: 1'b0, load: 1'b0,
                  pop: 1'b0, start: 1'b0, ack: 1'b0};
    end
    else
    begin
      cur_ff <= nxt_ff;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata  = cur_ff.rdata;
  assign call_start = cur_ff.start;
  assign call_busy  = (cur_ff.state == IPV_CALL);
  assign stack_push = cur_ff.push;
  assign push_pc    = cur_ff.pc_hold;
  assign pc_load    = cur_ff.load;
  assign pc_vector  = cur_ff.vec;
  assign stack_pop  = cur_ff.pop;
  assign ack_src    = cur_ff.win;
  assign ack_valid  = cur_ff.ack;
  assign in_service = cur_ff.isr;
  assign wake_up    = ~cur_ff.pin_s2[0] | ~cur_ff.pin_s2[1]
                      | (cur_ff.edge_flag != 2'h0); // see RULE17

  // ==========================================================
  // Assertions
  sequence s_call_body;
    call_busy [*4] ##1 !call_busy;
  endsequence

  a_call_length: assert property (@(posedge clk) // see RULE9
    $rose(call_busy) |-> s_call_body)
    else $error("Vector call not four cycles");
  a_load_after_push: assert property (@(posedge clk) // see RULE6
    stack_push |-> ##2 pc_load)
    else $error("Vector load not after push");
  a_call_last_cyc: assert property (@(posedge clk) // see RULE3
    call_start |-> $past(instr_last_cycle) && !$past(instr_writes_ie))
    else $error("Call outside instruction end");
  a_no_call_return_from_interrupt: assert property (@(posedge clk) // see RULE4
    call_start |-> !$past(instr_is_return_from_interrupt))
    else $error("Call during interrupt return");
  a_return_from_interrupt_pops: assert property (@(posedge clk) // see RULE7
    (instr_is_return_from_interrupt && instr_last_cycle && !call_busy) |=> stack_pop)
    else $error("Return did not pop");
  a_ret_keeps_isr: assert property (@(posedge clk) // see RULE8
    (instr_is_ret && !instr_is_return_from_interrupt && !take && !call_busy
     && instr_last_cycle) |=> in_service == $past(in_service))
    else $error("Plain return changed service state");
  a_level_follow: assert property (@(posedge clk) // see RULE14
    (!cur_ff.type_sel[0]) |-> ext_flag[0] == !$past(cur_ff.pin_s1[0]))
    else $error("Level flag not inverse of pin");
  a_edge_sets: assert property (@(posedge clk) // see RULE12
    (cur_ff.type_sel[0] && fall[0]) |=> cur_ff.edge_flag[0])
    else $error("Falling edge did not set flag");
  a_nest_block: assert property (@(posedge clk) // see RULE2
    call_start |-> (in_service & ~$past(in_service)) > $past(in_service))
    else $error("Call while equal or higher level serviced");

endmodule : ipv_ctrl

`default_nettype wire

// ---- ipv_core_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module ipv_core_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Call and return strobes
  input  wire logic        stack_push,
  input  wire logic [15:0] push_pc,
  input  wire logic        pc_load,
  input  wire logic [15:0] pc_vector,
  input  wire logic        stack_pop,
  // Core state
  output logic      [15:0] core_pc,
  output logic      [3:0]  depth
);

  // ==========================================================
  // Program counter and stack
  logic [15:0] stk [16];

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      core_pc <= 16'h0100;
      depth   <= 4'h0;
      for (int i = 0; i < 16; i++)
        stk[i] <= 16'h0000;
    end
    else if (stack_push)
    begin
      stk[depth] <= push_pc;
      depth      <= depth + 4'h1;
      core_pc    <= core_pc + 16'h0001;
    end
    else if (pc_load)
      core_pc <= pc_vector;
    else if (stack_pop)
    begin
      // Popped without any checking
      core_pc <= stk[depth - 4'h1];
      depth   <= depth - 4'h1;
    end
    else
      core_pc <= core_pc + 16'h0001;
  end

endmodule : ipv_core_model

`default_nettype wire

// ---- tb_interrupt_priority_and_vectoring.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb_interrupt_priority_and_vectoring
  import ipv_pkg::*;
;

  logic        clk = 1'b0;
  logic        nrst, reg_wr, reg_rd;
  logic        ext_irq_pin_zero, ext_irq_pin_one;
  logic        instr_last_cycle, instr_writes_ie;
  logic        instr_is_return_from_interrupt, instr_is_ret;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [11:0] src_flag;
  logic [15:0] core_pc, push_pc, pc_vector;
  logic        call_start, call_busy, stack_push, pc_load;
  logic        stack_pop, ack_valid, wake_up;
  logic [3:0]  ack_src, in_service, depth;
  int          err_total, total_checks;

  localparam logic [7:0] OFS [4] = '{OFS_PRIO_LOW_FIRST,
    OFS_PRIO_HIGH_FIRST, OFS_PRIO_LOW_SECOND, OFS_PRIO_HIGH_SECOND};
  localparam logic [7:0] MSK [4] = '{MASK_FIRST, MASK_FIRST,
    MASK_SECOND, MASK_SECOND};

  ipv_ctrl dut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_irq_pin_zero, .ext_irq_pin_one, .src_flag,
    .instr_last_cycle, .instr_writes_ie, .instr_is_return_from_interrupt, .instr_is_ret,
    .core_pc, .call_start, .call_busy, .stack_push, .push_pc, .pc_load,
    .pc_vector, .stack_pop, .ack_src, .ack_valid, .in_service, .wake_up);

  ipv_core_model core (.clk, .nrst, .stack_push, .push_pc, .pc_load,
    .pc_vector, .stack_pop, .core_pc, .depth);

  always #10 clk = ~clk;

  // ==========================================================
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : stop_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(16'(reg_rdata), 16'(e));
  endtask : rd

  // Control bits are ret, return_from_interrupt, writes_ie, last_cycle
  task automatic step(input logic [11:0] f, input logic [3:0] c);
    @(posedge clk);
    src_flag <= f;
    {instr_is_ret, instr_is_return_from_interrupt, instr_writes_ie, instr_last_cycle} <= c;
    @(posedge clk);
    src_flag <= 12'h000;
    {instr_is_ret, instr_is_return_from_interrupt, instr_writes_ie, instr_last_cycle} <= 4'h0;
    #1;
  endtask : step

  task automatic nocall(input logic [11:0] f, input logic [3:0] c);
    step(f, c);
    check(16'(call_start), 16'h0000);
  endtask : nocall

  task automatic call_chk(input logic [11:0] f, input logic [3:0] s,
                          input logic [3:0] v);
    step(f, 4'h1);
    check(16'({call_start, stack_push, ack_valid}), 16'h0007);
    check(push_pc, core_pc - 16'h0001);
    check(16'(ack_src), 16'(s));
    check(16'(in_service), 16'(v));
    repeat (2) @(posedge clk);
    #1 check(16'(pc_load), 16'h0001);
    check(pc_vector, VEC_TABLE[s]);
    @(posedge clk);
    #1 check(16'(call_busy), 16'h0001);
    @(posedge clk);
    #1 check(16'(call_busy), 16'h0000);
  endtask : call_chk

  task automatic ret_chk(input logic [11:0] f, input logic [3:0] c,
                         input logic [3:0] v);
    nocall(f, c);
    check(16'(stack_pop), 16'h0001);
    check(16'(in_service), 16'(v));
  endtask : ret_chk

  // ==========================================================
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total++;
    stop_test();
  end

  // ==========================================================
  // Tests
  initial
  begin
    nrst = 1'b0;
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {ext_irq_pin_zero, ext_irq_pin_one} = 2'b11;
    {instr_last_cycle, instr_writes_ie, instr_is_return_from_interrupt} = 3'h0;
    instr_is_ret = 1'b0;
    src_flag = 12'h000;
    err_total = 0;
    total_checks = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rd(OFS[i], 8'h00);
      wr(OFS[i], 8'hff);
      rd(OFS[i], MSK[i]);
      wr(OFS[i], 8'h00);
    end
    wr(8'h80, 8'hff);
    rd(8'h80, 8'h00);
    $display("Test registers done");
    call_chk(12'h060, 4'd5, 4'h1);
    ret_chk(12'h000, 4'h5, 4'h0);
    wr(OFS_PRIO_LOW_FIRST, 8'h10);
    wr(OFS_PRIO_HIGH_FIRST, 8'h01);
    wr(OFS_PRIO_LOW_SECOND, 8'h01);
    wr(OFS_PRIO_HIGH_SECOND, 8'h01);
    call_chk(12'h206, 4'd9, 4'h8);
    ret_chk(12'h000, 4'h5, 4'h0);
    call_chk(12'h006, 4'd2, 4'h4);
    call_chk(12'h200, 4'd9, 4'hc);
    check(16'(depth), 16'h0002);
    ret_chk(12'h000, 4'h5, 4'h4);
    nocall(12'h002, 4'h1);
    ret_chk(12'h002, 4'h5, 4'h0);
    nocall(12'h000, 4'h1);
    nocall(12'h002, 4'h3);
    nocall(12'h002, 4'h0);
    call_chk(12'h002, 4'd1, 4'h2);
    ret_chk(12'h000, 4'h9, 4'h2);
    nocall(12'h002, 4'h1);
    ret_chk(12'h000, 4'h5, 4'h0);
    $display("Test priority done");
    wr(OFS_EXT_CTRL, 8'h01);
    @(posedge clk);
    ext_irq_pin_zero <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check(16'(wake_up), 16'h0001);
    rd(OFS_EXT_CTRL, 8'h03);
    call_chk(12'h000, 4'd0, 4'h1);
    rd(OFS_EXT_CTRL, 8'h01);
    @(posedge clk);
    ext_irq_pin_zero <= 1'b1;
    ret_chk(12'h000, 4'h5, 4'h0);
    @(posedge clk);
    ext_irq_pin_one <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFS_EXT_CTRL, 8'h09);
    call_chk(12'h000, 4'd3, 4'h1);
    rd(OFS_EXT_CTRL, 8'h09);
    ret_chk(12'h000, 4'h5, 4'h0);
    call_chk(12'h000, 4'd3, 4'h1);
    @(posedge clk);
    ext_irq_pin_one <= 1'b1;
    ret_chk(12'h000, 4'h5, 4'h0);
    repeat (3) @(posedge clk);
    rd(OFS_EXT_CTRL, 8'h01);
    check(16'(wake_up), 16'h0000);
    $display("Test external pins done");
    stop_test();
  end

endmodule : tb_interrupt_priority_and_vectoring

`default_nettype wire
